// [hdl/sdc_regs_defs.vh]
`ifndef SDC_REGS_DEFS_VH
`define SDC_REGS_DEFS_VH

// Register byte addresses
`define SDC_ADDR_MEM_TYPE   32'hffffe820
`define SDC_ADDR_DLL_STAT   32'hffffe824
`define SDC_ADDR_READ_SPEED 32'hffffe82c
`define SDC_ADDR_IRQ_STAT   32'hffffe830
`define SDC_ADDR_IRQ_MASK   32'hffffe834
`define SDC_ADDR_WP_MODE    32'hfffe8e4
`define SDC_ADDR_WP_STAT    32'hfffe8e8

// Memory type configuration fields
`define SDC_MEMTYPE_LSB     0
`define SDC_MEMTYPE_MSB     2
`define SDC_BUSWIDTH_BIT    4
`define SDC_MEMTYPE_SDR     3'h0
`define SDC_MEMTYPE_LPSDR   3'h1
`define SDC_MEMTYPE_RSVD    3'h2
`define SDC_MEMTYPE_LPDDR1  3'h3
`define SDC_MEMTYPE_DDR2    3'h4
`define SDC_MEMTYPE_RESET   3'h0
`define SDC_BUSWIDTH_RESET  1'h1

// Delay loop status fields
`define SDC_DLL_INC_BIT     0
`define SDC_DLL_DEC_BIT     1
`define SDC_DLL_OVF_BIT     2
`define SDC_DLL_VAL_LSB     8
`define SDC_DLL_VAL_MSB     15

// Read speed configuration
`define SDC_EARLYDIS_BIT    2
`define SDC_EARLYDIS_RESET  1'h1

// Write protection
`define SDC_KEY_LSB         8
`define SDC_KEY_MSB         31
`define SDC_KEY_VALUE       24'h444452
`define SDC_PROT_EN_BIT     0
`define SDC_VIOL_FLAG_BIT   0
`define SDC_VIOL_SRC_LSB    8
`define SDC_VIOL_SRC_MSB    23

// Interrupt status and mask bits
`define SDC_IRQ_VIOL_BIT    0
`define SDC_IRQ_OVF_BIT     1
`define SDC_IRQ_WIDTH       2

`endif

// [hdl/sdc_delay_loop.v]
`default_nettype none

module sdc_delay_loop #(
    parameter CNT_W = 8
) (
    input  wire             ref_clk,
    input  wire             rst,
    input  wire             ce,
    input  wire             restart,
    input  wire             needMore,
    input  wire             needLess,
    output reg  [CNT_W-1:0] delayCount_reg,
    output reg              incFlag_reg,
    output reg              decFlag_reg,
    output reg              ovfFlag_reg
);

    localparam [2:0] ST_SEEK = 3'b001;
    localparam [2:0] ST_LOCK = 3'b010;
    localparam [2:0] ST_OVF  = 3'b100;
    localparam [CNT_W-1:0] CNT_MAX  = {CNT_W{1'b1}};
    localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
    localparam [CNT_W-1:0] CNT_ONE  = {{(CNT_W-1){1'b0}}, 1'b1};

    reg [2:0]       state_reg;
    reg [2:0]       state_next;
    reg [CNT_W-1:0] count_next;
    reg             inc_next;
    reg             dec_next;

    always @* begin
        state_next = state_reg;
        count_next = delayCount_reg;
        inc_next   = 1'b0;
        dec_next   = 1'b0;
        case (state_reg)
            ST_SEEK, ST_LOCK: begin
                if (needMore && delayCount_reg == CNT_MAX) begin
                    state_next = ST_OVF;
                end else if (needMore) begin
                    count_next = delayCount_reg + CNT_ONE;
                    inc_next   = 1'b1;
                    state_next = ST_SEEK;
                end else if (needLess && delayCount_reg != CNT_ZERO) begin
                    count_next = delayCount_reg - CNT_ONE;
                    dec_next   = 1'b1;
                    state_next = ST_SEEK;
                end else begin
                    state_next = ST_LOCK;
                end
            end
            ST_OVF: begin
                // Forced lock holds until the loop is restarted
                state_next = ST_OVF;
            end
            default: begin
                state_next = ST_SEEK;
            end
        endcase
        if (restart) begin
            state_next = ST_SEEK;
            count_next = CNT_ZERO;
            inc_next   = 1'b0;
            dec_next   = 1'b0;
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg      <= ST_SEEK;
            delayCount_reg <= {CNT_W{1'b0}};
            incFlag_reg    <= 1'b0;
            decFlag_reg    <= 1'b0;
            ovfFlag_reg    <= 1'b0;
        end else if (ce) begin
            state_reg      <= state_next;
            delayCount_reg <= count_next;
            incFlag_reg    <= inc_next;
            decFlag_reg    <= dec_next;
            ovfFlag_reg    <= (state_next == ST_OVF);
        end
    end

endmodule

`default_nettype wire

// [hdl/sdc_config_protect.v]
// Implementation choice: the address-and-strobe port.
`include "sdc_regs_defs.vh"
`default_nettype none

module sdc_config_protect #(
    parameter CNT_W = 8
) (
    input  wire             ref_clk,
    input  wire             rst,
    input  wire             ce,
    input  wire [31:0]      busAddr,
    input  wire [31:0]      busWdata,
    input  wire             busWrite,
    input  wire             busRead,
    output reg  [31:0]      busRdata_reg,
    input  wire             dllRestart,
    input  wire             strobeEarly,
    input  wire             strobeLate,
    output wire [CNT_W-1:0] strobeDelayTap,
    output reg  [2:0]       memType_reg,
    output reg              busWidth16_reg,
    output wire             earlyReadEnable,
    output wire             memIsDdr,
    output wire             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    wire selMemType  = (busAddr == `SDC_ADDR_MEM_TYPE);
    wire selDllStat  = (busAddr == `SDC_ADDR_DLL_STAT);
    wire selSpeed    = (busAddr == `SDC_ADDR_READ_SPEED);
    wire selIrqStat  = (busAddr == `SDC_ADDR_IRQ_STAT);
    wire selIrqMask  = (busAddr == `SDC_ADDR_IRQ_MASK);
    wire selWpMode   = (busAddr == `SDC_ADDR_WP_MODE);
    wire selWpStat   = (busAddr == `SDC_ADDR_WP_STAT);

    reg                     protectEn_reg;
    reg                     earlyReadDis_reg;
    reg                     violFlag_reg;
    reg  [15:0]             violSrc_reg;
    reg  [`SDC_IRQ_WIDTH-1:0] irqStat_reg;
    reg  [`SDC_IRQ_WIDTH-1:0] irqMask_reg;
    reg                     ovfSeen_reg;

    wire [CNT_W-1:0] dllCount;
    wire             dllInc;
    wire             dllDec;
    wire             dllOvf;

    wire guardedSel = selMemType | selSpeed;
    wire guardedWriteOk  = busWrite & guardedSel & ~protectEn_reg;
    wire violationEvent  = busWrite & guardedSel & protectEn_reg;
    // key must match for the enable bit
    wire keyOk = (busWdata[`SDC_KEY_MSB:`SDC_KEY_LSB] == `SDC_KEY_VALUE);
    wire ovfEvent = dllOvf & ~ovfSeen_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Delay loop

    // strobe delay tap follows the master count
    sdc_delay_loop #(
        .CNT_W (CNT_W)
    ) sdc_delay_loop_i (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .ce             (ce),
        .restart        (dllRestart),
        .needMore       (strobeEarly),
        .needLess       (strobeLate),
        .delayCount_reg (dllCount),
        .incFlag_reg    (dllInc),
        .decFlag_reg    (dllDec),
        .ovfFlag_reg    (dllOvf)
    );

    assign strobeDelayTap = dllCount;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and protection registers

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            memType_reg      <= `SDC_MEMTYPE_RESET;
            busWidth16_reg   <= `SDC_BUSWIDTH_RESET;
            earlyReadDis_reg <= `SDC_EARLYDIS_RESET;
            protectEn_reg    <= 1'b0;
        end else if (ce) begin
            if (guardedWriteOk && selMemType) begin
                memType_reg    <= busWdata[`SDC_MEMTYPE_MSB:`SDC_MEMTYPE_LSB];
                busWidth16_reg <= busWdata[`SDC_BUSWIDTH_BIT];
            end
            if (guardedWriteOk && selSpeed) begin
                earlyReadDis_reg <= busWdata[`SDC_EARLYDIS_BIT];
            end
            if (busWrite && selWpMode && keyOk) begin
                protectEn_reg <= busWdata[`SDC_PROT_EN_BIT];
            end
        end
    end

    assign earlyReadEnable = ~earlyReadDis_reg;
    assign memIsDdr = (memType_reg == `SDC_MEMTYPE_LPDDR1) | (memType_reg == `SDC_MEMTYPE_DDR2);

    ////////////////////////////////////////////////////////////////////////////
    // Violation status

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            violFlag_reg <= 1'b0;
            violSrc_reg  <= 16'h0000;
        end else if (ce) begin
            if (violationEvent) begin
                // record offending offset, set wins over read clear
                violFlag_reg <= 1'b1;
                violSrc_reg  <= busAddr[15:0];
            end else if (busRead && selWpStat) begin
                violFlag_reg <= 1'b0;
                violSrc_reg  <= 16'h0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts

    wire [`SDC_IRQ_WIDTH-1:0] irqSet = {ovfEvent, violationEvent};
    wire [`SDC_IRQ_WIDTH-1:0] irqClr = (busWrite && selIrqStat) ?
                                       busWdata[`SDC_IRQ_WIDTH-1:0] : {`SDC_IRQ_WIDTH{1'b0}};

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irqStat_reg <= {`SDC_IRQ_WIDTH{1'b0}};
            irqMask_reg <= {`SDC_IRQ_WIDTH{1'b0}};
            ovfSeen_reg <= 1'b0;
        end else if (ce) begin
            // Set wins over write-one-to-clear
            irqStat_reg <= (irqStat_reg & ~irqClr) | irqSet;
            ovfSeen_reg <= dllOvf;
            if (busWrite && selIrqMask) begin
                irqMask_reg <= busWdata[`SDC_IRQ_WIDTH-1:0];
            end
        end
    end

    assign irq = |(irqStat_reg & irqMask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe

    reg [31:0] rdata_next;

    always @* begin
        rdata_next = 32'h00000000;
        if (busRead) begin
            if (selMemType) begin
                rdata_next[`SDC_MEMTYPE_MSB:`SDC_MEMTYPE_LSB] = memType_reg;
                rdata_next[`SDC_BUSWIDTH_BIT] = busWidth16_reg;
            end
            if (selDllStat) begin
                rdata_next[`SDC_DLL_INC_BIT] = dllInc;
                rdata_next[`SDC_DLL_DEC_BIT] = dllDec;
                rdata_next[`SDC_DLL_OVF_BIT] = dllOvf;
                rdata_next[`SDC_DLL_VAL_MSB:`SDC_DLL_VAL_LSB] = dllCount[7:0];
            end
            if (selSpeed) begin
                rdata_next[`SDC_EARLYDIS_BIT] = earlyReadDis_reg;
            end
            if (selWpMode) begin
                rdata_next[`SDC_PROT_EN_BIT] = protectEn_reg;
            end
            if (selWpStat) begin
                rdata_next[`SDC_VIOL_FLAG_BIT] = violFlag_reg;
                rdata_next[`SDC_VIOL_SRC_MSB:`SDC_VIOL_SRC_LSB] = violSrc_reg;
            end
            if (selIrqStat) begin
                rdata_next[`SDC_IRQ_WIDTH-1:0] = irqStat_reg;
            end
            if (selIrqMask) begin
                rdata_next[`SDC_IRQ_WIDTH-1:0] = irqMask_reg;
            end
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busRdata_reg <= 32'h00000000;
        end else if (ce) begin
            busRdata_reg <= rdata_next;
        end
    end

endmodule

`default_nettype wire

// [tb/sdc_cp_properties.sv]
`include "sdc_regs_defs.vh"
`default_nettype none
module sdc_cp_properties #(
    parameter CNT_W = 8
) (
    input wire logic             ref_clk,
    input wire logic             rst,
    input wire logic             ce,
    input wire logic [31:0]      busAddr,
    input wire logic [31:0]      busWdata,
    input wire logic             busWrite,
    input wire logic             busRead,
    input wire logic [31:0]      busRdata_reg,
    input wire logic             dllRestart,
    input wire logic             strobeEarly,
    input wire logic             strobeLate,
    input wire logic [CNT_W-1:0] strobeDelayTap,
    input wire logic [2:0]       memType_reg,
    input wire logic             busWidth16_reg,
    input wire logic             earlyReadEnable,
    input wire logic             memIsDdr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic protOn;
    wire  tapMax = strobeDelayTap == {CNT_W{1'b1}};
    wire  wrCfg  = ce && busWrite && busAddr == `SDC_ADDR_MEM_TYPE;
    wire  wrSpd  = ce && busWrite && busAddr == `SDC_ADDR_READ_SPEED;
    // Shadow of the protection state, keyed writes only
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            protOn <= 1'b0;
        else if (ce && busWrite && busAddr == `SDC_ADDR_WP_MODE && busWdata[31:8] == `SDC_KEY_VALUE)
            protOn <= busWdata[0];
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    a_read_one_cycle: assert property ($past(ce) && !$past(busRead) |-> busRdata_reg == 32'h0)
        else $error("read data outside its cycle");
    a_key_reads_zero: assert property (ce && busRead && busAddr == `SDC_ADDR_WP_MODE |=> busRdata_reg[31:8] == 24'h0)
        else $error("key field not zero");
    a_type_written: assert property (wrCfg && !protOn |=> memType_reg == $past(busWdata[2:0])
        && busWidth16_reg == $past(busWdata[4]))
        else $error("memory type write lost");
    a_type_blocked: assert property (!(wrCfg && !protOn) |=> $stable(memType_reg) && $stable(busWidth16_reg))
        else $error("memory type changed while blocked");
    a_speed_written: assert property (wrSpd && !protOn |=> earlyReadEnable == !$past(busWdata[2]))
        else $error("early read bit write lost");
    a_speed_blocked: assert property (wrSpd && protOn |=> $stable(earlyReadEnable))
        else $error("early read bit changed while blocked");
    a_ddr_decode: assert property (memIsDdr == (memType_reg == 3'h3 || memType_reg == 3'h4))
        else $error("ddr decode wrong");
    a_tap_up: assert property (ce && strobeEarly && !tapMax && !dllRestart
        |=> strobeDelayTap == $past(strobeDelayTap) + 1'b1)
        else $error("tap did not step up");
    a_tap_down: assert property (ce && !strobeEarly && strobeLate && strobeDelayTap != 0 && !tapMax && !dllRestart
        |=> strobeDelayTap == $past(strobeDelayTap) - 1'b1)
        else $error("tap did not step down");
    a_tap_frozen: assert property (ce && tapMax && strobeEarly && !dllRestart |=> tapMax)
        else $error("tap left maximum");
endmodule
bind sdc_config_protect sdc_cp_properties #(.CNT_W(CNT_W)) sdc_cp_properties_i (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .busAddr(busAddr), .busWdata(busWdata),
    .busWrite(busWrite), .busRead(busRead), .busRdata_reg(busRdata_reg), .dllRestart(dllRestart),
    .strobeEarly(strobeEarly), .strobeLate(strobeLate), .strobeDelayTap(strobeDelayTap),
    .memType_reg(memType_reg), .busWidth16_reg(busWidth16_reg), .earlyReadEnable(earlyReadEnable),
    .memIsDdr(memIsDdr));
`default_nettype wire

// [tb/sdc_strobe_model.sv]
`default_nettype none
// Phase detector of the memory side: asks for delay until the tap sits on centreTap
module sdc_strobe_model (
    input  wire logic [7:0] strobeTap,
    input  wire logic [8:0] centreTap,
    output logic            moreDelay,
    output logic            lessDelay
);
    timeunit 1ns;
    timeprecision 1ps;
    assign moreDelay = {1'b0, strobeTap} < centreTap;
    assign lessDelay = {1'b0, strobeTap} > centreTap;
endmodule
`default_nettype wire

// [tb/sdram_ctrl_config_protect_tb.sv]
`include "sdc_regs_defs.vh"
`default_nettype none
module sdram_ctrl_config_protect_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, rst, ce, busWrite, busRead, dllRestart;
    logic        rdSeen = 1'b0;
    logic [31:0] busAddr, busWdata, d, w;
    logic [8:0]  centreTap;
    logic [63:0] e;
    logic [63:0] expQ[$];
    wire  [31:0] rdata;
    wire  [7:0]  tap;
    wire  [2:0]  memType;
    wire         width16, earlyEn, isDdr, irq, early, late;
    int          err_total, checks, i;
    int          seed = 32'h738562f0;
    sdc_config_protect sdc_config_protect_i (.ref_clk(ref_clk), .rst(rst), .ce(ce), .busAddr(busAddr),
        .busWdata(busWdata), .busWrite(busWrite), .busRead(busRead), .busRdata_reg(rdata),
        .dllRestart(dllRestart), .strobeEarly(early), .strobeLate(late), .strobeDelayTap(tap),
        .memType_reg(memType), .busWidth16_reg(width16), .earlyReadEnable(earlyEn), .memIsDdr(isDdr), .irq(irq));
    sdc_strobe_model sdc_strobe_model_i (.strobeTap(tap), .centreTap(centreTap), .moreDelay(early), .lessDelay(late));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task end_of_test;
        if (err_total == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task bus(input logic wrEn, input logic rdEn, input logic [31:0] a, input logic [31:0] dat);
        busWrite <= wrEn;
        busRead  <= rdEn;
        busAddr  <= a;
        busWdata <= dat;
        @(posedge ref_clk);
    endtask
    task wr(input logic [31:0] a, input logic [31:0] dat);
        bus(1'b1, 1'b0, a, dat);
    endtask
    task rd(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
        expQ.push_back({m, exp});
        bus(1'b0, 1'b1, a, 32'h0);
    endtask
    task idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 32'h0, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////
    // Read data is taken in the cycle after each read strobe
    always @(posedge ref_clk) begin
        if (rdSeen && expQ.size() > 0) begin
            e = expQ.pop_front();
            check(rdata & e[63:32], e[31:0], "read data");
        end
        rdSeen <= busRead && !rst;
    end
    initial begin
        #400000;
        err_total++;
        end_of_test;
    end
    initial begin
        rst = 1'b1; busWrite = 1'b0; busRead = 1'b0; busAddr = 32'h0; busWdata = 32'h0;
        dllRestart = 1'b0; centreTap = 9'h0; ce = 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(`SDC_ADDR_MEM_TYPE, 32'h10);
        rd(`SDC_ADDR_READ_SPEED, 32'h4);
        rd(`SDC_ADDR_WP_STAT, 32'h0);
        rd(`SDC_ADDR_IRQ_MASK, 32'h0);
        for (i = 0; i < 5; i++) begin
            w = $random(seed);
            d = {27'h0, w[0], 1'b0, i[2:0]};
            wr(`SDC_ADDR_MEM_TYPE, d);
            rd(`SDC_ADDR_MEM_TYPE, d);
            idle(1);
            check({31'h0, isDdr}, {31'h0, i == 3 || i == 4}, "ddr decode");
            check({31'h0, width16}, {31'h0, w[0]}, "bus width");
        end
        wr(`SDC_ADDR_READ_SPEED, 32'h0);
        rd(`SDC_ADDR_READ_SPEED, 32'h0);
        wr(`SDC_ADDR_WP_MODE, {24'h444453, 8'h01});
        wr(`SDC_ADDR_MEM_TYPE, 32'h13);
        rd(`SDC_ADDR_MEM_TYPE, 32'h13);
        rd(`SDC_ADDR_WP_STAT, 32'h0);
        wr(`SDC_ADDR_WP_MODE, {24'h444452, 8'h01});
        rd(`SDC_ADDR_WP_MODE, 32'h1);
        wr(`SDC_ADDR_MEM_TYPE, 32'h04);
        rd(`SDC_ADDR_MEM_TYPE, 32'h13);
        rd(`SDC_ADDR_WP_STAT, 32'h00e82001);
        rd(`SDC_ADDR_WP_STAT, 32'h0);
        wr(`SDC_ADDR_READ_SPEED, 32'h4);
        rd(`SDC_ADDR_READ_SPEED, 32'h0);
        check({31'h0, irq}, 32'h0, "masked irq");
        wr(`SDC_ADDR_IRQ_MASK, 32'h1);
        idle(1);
        check({31'h0, irq}, 32'h1, "irq raised");
        rd(`SDC_ADDR_WP_STAT, 32'h00e82c01);
        wr(`SDC_ADDR_IRQ_STAT, 32'h1);
        idle(1);
        check({31'h0, irq}, 32'h0, "irq cleared");
        wr(`SDC_ADDR_DLL_STAT, 32'hffffffff);
        rd(`SDC_ADDR_DLL_STAT, 32'h0);
        wr(32'hffffe840, 32'h1);
        rd(32'hffffe840, 32'h0);
        wr(`SDC_ADDR_WP_MODE, {24'h444452, 8'h00});
        wr(`SDC_ADDR_MEM_TYPE, 32'h04);
        rd(`SDC_ADDR_MEM_TYPE, 32'h04);
        idle(1);
        ce <= 1'b0;
        wr(`SDC_ADDR_MEM_TYPE, 32'h13);
        ce <= 1'b1;
        rd(`SDC_ADDR_MEM_TYPE, 32'h04);
        centreTap <= 9'h5;
        idle(20);
        rd(`SDC_ADDR_DLL_STAT, 32'h0500);
        centreTap <= 9'h2;
        idle(20);
        rd(`SDC_ADDR_DLL_STAT, 32'h0200);
        centreTap <= 9'h1ff;
        idle(300);
        rd(`SDC_ADDR_DLL_STAT, 32'hff04, 32'hff04);
        rd(`SDC_ADDR_IRQ_STAT, 32'h2, 32'h2);
        wr(`SDC_ADDR_IRQ_MASK, 32'h3);
        idle(1);
        check({31'h0, irq}, 32'h1, "overflow irq");
        wr(`SDC_ADDR_IRQ_STAT, 32'h2);
        idle(1);
        check({31'h0, irq}, 32'h0, "overflow irq cleared");
        dllRestart <= 1'b1;
        centreTap  <= 9'h3;
        idle(1);
        dllRestart <= 1'b0;
        idle(20);
        rd(`SDC_ADDR_DLL_STAT, 32'h0300);
        idle(2);
        end_of_test;
    end
endmodule
`default_nettype wire
